// File: output_driver_param_regs.v
// Operation
// - Trace HD swing: 6 bits at 13:8 of 0x2d, range 0..40, reset 0x11.
// - Trace HD swing sets trace amplitude; reset gives about 400 mVppd.
// - Cable pre-emphasis width: 5 bits at 12:8 of 0x2e, 0..15, reset 9.
// - Bit 6 of 0x2e controls the cable pre-emphasis driver, reset 0.
// - Power-down 0 keeps pre-emphasis powered and on, 1 turns it off.
// - Cable pre-emphasis level: 6 bits at 5:0 of 0x2e, 0..15, reset 7.
// - Cable swing: 6 bits at 13:8 of 0x2f, about 20 mVpp per step.
// - With automatic slew on, slew follows the locked recovery rate.
// - With automatic slew on and recovery unlocked, 6G/12G slew is used.
`include "output_driver_param_defs.vh"
`default_nettype none

module output_driver_param_regs (
	input  wire       ref_clk_in,
	input  wire       rst_in,
	input  wire       ser_clk_in,
	input  wire       ser_sel_n_in,
	input  wire       ser_data_in,
	output reg        ser_data_out,
	output reg        ser_data_oe_n_out,
	input  wire       automatic_slew_select_in,
	input  wire [1:0] manual_slew_in,
	input  wire       recovery_locked_in,
	input  wire [2:0] recovery_rate_in,
	output reg  [5:0] trace_hd_swing_out,
	output reg  [4:0] cable_hd_preemph_width_out,
	output reg        cable_hd_preemph_off_out,
	output reg        cable_hd_preemph_on_out,
	output reg  [5:0] cable_hd_preemph_level_out,
	output reg  [5:0] cable_hd_swing_out,
	output reg  [1:0] slew_select_out
);

	wire [2:0]  pins_s;
	wire        sclk_s;
	wire        sel_n_s;
	wire        sdi_s;
	reg         sclk_prev_q;
	reg  [5:0]  bit_cnt_q;
	reg  [5:0]  bit_cnt_d;
	reg  [15:0] hdr_q;
	reg  [15:0] hdr_d;
	reg  [15:0] wdata_q;
	reg  [15:0] wdata_d;
	reg  [15:0] rsh_q;
	reg  [15:0] rsh_d;
	reg         sdo_d;
	reg         oe_n_d;
	reg  [15:0] trace_amp_q;
	reg  [15:0] trace_amp_d;
	reg  [15:0] cable_pre_q;
	reg  [15:0] cable_pre_d;
	reg  [15:0] cable_swg_q;
	reg  [15:0] cable_swg_d;
	reg  [15:0] rd_word;
	reg  [15:0] hdr_next;
	reg  [15:0] wdata_next;
	reg  [5:0]  tr_swing;
	reg  [4:0]  pre_width;
	reg  [5:0]  pre_level;
	reg  [1:0]  slew_d;
	wire        rise;
	wire        fall;

	// Pins come from the host's domain
	pin_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.async_in   ({ser_clk_in, ser_sel_n_in, ser_data_in}),
		.sync_out   (pins_s)
	);

	assign sclk_s  = pins_s[2];
	assign sel_n_s = pins_s[1];
	assign sdi_s   = pins_s[0];
	assign rise    = sclk_s & ~sclk_prev_q;
	assign fall    = ~sclk_s & sclk_prev_q;

	// Read mux, unmapped addresses read zero
	always @* begin
		case (hdr_q[`FRAME_ADDR_MSB:0])
			`TRACE_HD_AMPLITUDE_ADDR: rd_word = trace_amp_q;
			`CABLE_HD_PREEMPH_ADDR:   rd_word = cable_pre_q;
			`CABLE_HD_SWING_ADDR:     rd_word = cable_swg_q;
			default:                  rd_word = 16'h0000;
		endcase
	end

	// Serial frame: 16 header bits, then 16 data bits, MSB first
	always @* begin
		bit_cnt_d   = bit_cnt_q;
		hdr_d       = hdr_q;
		wdata_d     = wdata_q;
		rsh_d       = rsh_q;
		sdo_d       = ser_data_out;
		oe_n_d      = ser_data_oe_n_out;
		trace_amp_d = trace_amp_q;
		cable_pre_d = cable_pre_q;
		cable_swg_d = cable_swg_q;
		hdr_next    = {hdr_q[14:0], sdi_s};
		wdata_next  = {wdata_q[14:0], sdi_s};
		if (sel_n_s) begin
			// Deselect aborts any partial frame
			bit_cnt_d = 6'h00;
			oe_n_d    = 1'b1;
			sdo_d     = 1'b0;
		end else if (rise && bit_cnt_q < `FRAME_ALL_BITS) begin
			bit_cnt_d = bit_cnt_q + 6'h01;
			if (bit_cnt_q < `FRAME_HDR_BITS)
				hdr_d = hdr_next;
			else
				wdata_d = wdata_next;
			// Whole write frame commits on the last data bit
			if (bit_cnt_q == `FRAME_ALL_BITS - 6'h01 &&
			    !hdr_q[`FRAME_READ_BIT]) begin
				case (hdr_q[`FRAME_ADDR_MSB:0])
					`TRACE_HD_AMPLITUDE_ADDR: trace_amp_d = wdata_next;
					`CABLE_HD_PREEMPH_ADDR:   cable_pre_d = wdata_next;
					`CABLE_HD_SWING_ADDR:     cable_swg_d = wdata_next;
					default:                  cable_swg_d = cable_swg_q;
				endcase
			end
		end else if (bit_cnt_q == `FRAME_HDR_BITS && hdr_q[`FRAME_READ_BIT] &&
		             oe_n_d) begin
			// Header complete: present read MSB before first data clock
			rsh_d  = {rd_word[14:0], 1'b0};
			sdo_d  = rd_word[15];
			oe_n_d = 1'b0;
		end else if (fall && !ser_data_oe_n_out &&
		             bit_cnt_q > `FRAME_HDR_BITS) begin
			sdo_d = rsh_q[15];
			rsh_d = {rsh_q[14:0], 1'b0};
		end
	end

	// Saturate fields to their accepted ranges
	always @* begin
		tr_swing  = trace_amp_q[`TRACE_HD_SWING_MSB:`TRACE_HD_SWING_LSB];
		pre_width = cable_pre_q[`PREEMPH_WIDTH_MSB:`PREEMPH_WIDTH_LSB];
		pre_level = cable_pre_q[`PREEMPH_LEVEL_MSB:`PREEMPH_LEVEL_LSB];
		if (tr_swing > `TRACE_HD_SWING_MAX)
			tr_swing = `TRACE_HD_SWING_MAX;
		if (pre_width > `PREEMPH_WIDTH_MAX)
			pre_width = `PREEMPH_WIDTH_MAX;
		if (pre_level > `PREEMPH_LEVEL_MAX)
			pre_level = `PREEMPH_LEVEL_MAX;
	end

	// Slew choice; unknown locked rates also fall to the fast slew
	always @* begin
		if (!automatic_slew_select_in) begin
			slew_d = manual_slew_in;
		end else if (!recovery_locked_in) begin
			slew_d = `SLEW_6G_12G;
		end else begin
			case (recovery_rate_in)
				`RATE_SD:  slew_d = `SLEW_SD;
				`RATE_HD:  slew_d = `SLEW_HD_3G;
				`RATE_3G:  slew_d = `SLEW_HD_3G;
				default:   slew_d = `SLEW_6G_12G;
			endcase
		end
	end

	// Port state and registers
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			sclk_prev_q       <= 1'b0;
			bit_cnt_q         <= 6'h00;
			hdr_q             <= 16'h0000;
			wdata_q           <= 16'h0000;
			rsh_q             <= 16'h0000;
			ser_data_out      <= 1'b0;
			ser_data_oe_n_out <= 1'b1;
			trace_amp_q       <= `TRACE_HD_AMPLITUDE_RST;
			cable_pre_q       <= `CABLE_HD_PREEMPH_RST;
			cable_swg_q       <= `CABLE_HD_SWING_RST;
		end else begin
			sclk_prev_q       <= sclk_s;
			bit_cnt_q         <= bit_cnt_d;
			hdr_q             <= hdr_d;
			wdata_q           <= wdata_d;
			rsh_q             <= rsh_d;
			ser_data_out      <= sdo_d;
			ser_data_oe_n_out <= oe_n_d;
			trace_amp_q       <= trace_amp_d;
			cable_pre_q       <= cable_pre_d;
			cable_swg_q       <= cable_swg_d;
		end
	end

	// Driver controls, registered one cycle behind the bank and the slew inputs
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			trace_hd_swing_out         <= `TRACE_HD_SWING_RST;
			cable_hd_preemph_width_out <= `PREEMPH_WIDTH_RST;
			cable_hd_preemph_off_out   <= `PREEMPH_OFF_RST;
			cable_hd_preemph_on_out    <= ~`PREEMPH_OFF_RST;
			cable_hd_preemph_level_out <= `PREEMPH_LEVEL_RST;
			cable_hd_swing_out         <= `CABLE_SWING_FIELD_RST;
			slew_select_out            <= `SLEW_6G_12G;
		end else begin
			trace_hd_swing_out         <= tr_swing;
			cable_hd_preemph_width_out <= pre_width;
			cable_hd_preemph_off_out   <= cable_pre_q[`PREEMPH_OFF_BIT];
			cable_hd_preemph_on_out    <= ~cable_pre_q[`PREEMPH_OFF_BIT];
			cable_hd_preemph_level_out <= pre_level;
			// Range is software's duty, so no clamp here
			cable_hd_swing_out         <=
				cable_swg_q[`CABLE_HD_SWING_MSB:`CABLE_HD_SWING_LSB];
			slew_select_out            <= slew_d;
		end
	end

endmodule

`default_nettype wire

// File: output_driver_param_defs.vh
`ifndef OUTPUT_DRIVER_PARAM_DEFS_VH
`define OUTPUT_DRIVER_PARAM_DEFS_VH

// Register offsets
`define TRACE_HD_AMPLITUDE_ADDR   8'h2d
`define CABLE_HD_PREEMPH_ADDR     8'h2e
`define CABLE_HD_SWING_ADDR       8'h2f

// Reset values, reserved bits included
`define TRACE_HD_AMPLITUDE_RST    16'h1170
`define CABLE_HD_PREEMPH_RST      16'h0907
`define CABLE_HD_SWING_RST        16'h1700

// Reset values of the driver control outputs
`define TRACE_HD_SWING_RST        6'h11
`define PREEMPH_WIDTH_RST         5'h09
`define PREEMPH_OFF_RST           1'b0
`define PREEMPH_LEVEL_RST         6'h07
`define CABLE_SWING_FIELD_RST     6'h17

// Field positions
`define TRACE_HD_SWING_MSB        13
`define TRACE_HD_SWING_LSB        8
`define PREEMPH_WIDTH_MSB         12
`define PREEMPH_WIDTH_LSB         8
`define PREEMPH_OFF_BIT           6
`define PREEMPH_LEVEL_MSB         5
`define PREEMPH_LEVEL_LSB         0
`define CABLE_HD_SWING_MSB        13
`define CABLE_HD_SWING_LSB        8

// Largest accepted field values
`define TRACE_HD_SWING_MAX        6'h28
`define PREEMPH_WIDTH_MAX         5'h0f
`define PREEMPH_LEVEL_MAX         6'h0f

// Serial frame layout
`define FRAME_READ_BIT            15
`define FRAME_ADDR_MSB            7
`define FRAME_HDR_BITS            6'h10
`define FRAME_ALL_BITS            6'h20

// Locked rate codes from clock recovery
`define RATE_SD                   3'h0
`define RATE_HD                   3'h1
`define RATE_3G                   3'h2
`define RATE_6G                   3'h3
`define RATE_12G                  3'h4

// Slew selections
`define SLEW_SD                   2'h0
`define SLEW_HD_3G                2'h1
`define SLEW_6G_12G               2'h2

`endif

// File: pin_sync.v
`default_nettype none

// Two-stage synchroniser for a group of pin inputs
module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             ref_clk_in,
	input  wire             rst_in,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] stable_q;

	// First stage feeds only the second stage
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			meta_q   <= {WIDTH{1'b0}};
			stable_q <= {WIDTH{1'b0}};
		end else begin
			meta_q   <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;

endmodule

`default_nettype wire

// File: output_driver_param_monitor.sv
`default_nettype none
module output_driver_param_monitor (
	input wire logic       ref_clk_in,
	input wire logic       rst_in,
	input wire logic       ser_clk_in,
	input wire logic       ser_sel_n_in,
	input wire logic       ser_data_in,
	input wire logic       ser_data_out,
	input wire logic       ser_data_oe_n_out,
	input wire logic       automatic_slew_select_in,
	input wire logic [1:0] manual_slew_in,
	input wire logic       recovery_locked_in,
	input wire logic [2:0] recovery_rate_in,
	input wire logic [5:0] trace_hd_swing_out,
	input wire logic [4:0] cable_hd_preemph_width_out,
	input wire logic       cable_hd_preemph_off_out,
	input wire logic       cable_hd_preemph_on_out,
	input wire logic [5:0] cable_hd_preemph_level_out,
	input wire logic [5:0] cable_hd_swing_out,
	input wire logic [1:0] slew_select_out
);
	timeunit 1ns / 1ns;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// Saturated codes stay in range
	trace_sat_a: assert property (trace_hd_swing_out <= 6'h28)
		else $error("trace swing over range");
	width_sat_a: assert property (cable_hd_preemph_width_out <= 5'h0f)
		else $error("width over range");
	level_sat_a: assert property (cable_hd_preemph_level_out <= 6'h0f)
		else $error("level over range");
	// Driver enable is the inverse of power-down
	preemph_pair_a: assert property (
		cable_hd_preemph_on_out != cable_hd_preemph_off_out)
		else $error("enable not inverse");
	// Reset values still show at the first edge after release
	reset_vals_a: assert property ($fell(rst_in) |->
		trace_hd_swing_out == 6'h11 && cable_hd_preemph_width_out == 5'h09
		&& !cable_hd_preemph_off_out && cable_hd_preemph_level_out == 6'h07
		&& cable_hd_swing_out == 6'h17) else $error("bad reset value");
	// Unlocked recovery falls back to the fastest slew
	unlock_slew_a: assert property (
		automatic_slew_select_in && !recovery_locked_in
		|=> slew_select_out == 2'h2) else $error("unlocked slew wrong");
	locked_slew_a: assert property (
		automatic_slew_select_in && recovery_locked_in |=> slew_select_out ==
		($past(recovery_rate_in) == 3'h0 ? 2'h0 :
		$past(recovery_rate_in) < 3'h3 ? 2'h1 : 2'h2))
		else $error("locked slew wrong");
	manual_slew_a: assert property (
		!automatic_slew_select_in |=> slew_select_out == $past(manual_slew_in))
		else $error("manual slew wrong");
	// Main scenarios reached
	cover property (automatic_slew_select_in && recovery_locked_in);
	cover property (cable_hd_preemph_off_out);
	cover property (!ser_data_oe_n_out);
endmodule
bind output_driver_param_regs output_driver_param_monitor
	u_output_driver_param_monitor (.*);
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns / 1ns;
	logic       ref_clk_in = 1'b0, rst_in = 1'b1, ser_clk_in = 1'b0;
	logic       ser_sel_n_in = 1'b1, ser_data_in = 1'b0;
	logic       automatic_slew_select_in = 1'b1, recovery_locked_in = 1'b0;
	logic [1:0] manual_slew_in = 2'h0;
	logic [2:0] recovery_rate_in = 3'h0;
	logic       ser_data_out, ser_data_oe_n_out, cable_hd_preemph_off_out;
	logic       cable_hd_preemph_on_out;
	logic [5:0] trace_hd_swing_out, cable_hd_preemph_level_out;
	logic [5:0] cable_hd_swing_out;
	logic [4:0] cable_hd_preemph_width_out;
	logic [1:0] slew_select_out;
	logic [15:0] r;
	// Functional range ends and precision range ends
	logic [5:0] sw [4] = '{6'h09, 6'h14, 6'h1a, 6'h1f};
	logic [1:0] slew_exp [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
	int         fails = 0, samples_checked = 0;
	// 10 MHz core clock
	always #50 ref_clk_in = ~ref_clk_in;
	output_driver_param_regs u_output_driver_param_regs (.*);
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// One frame; 6-cycle halves clear the 4-cycle minimum and sync lag
	task automatic xfer(input logic rd, input logic [7:0] a,
		input logic [15:0] d);
		logic [31:0] f;
		f = {rd, 7'h00, a, d};
		r = 16'h0000;
		ser_sel_n_in <= 1'b0;
		tick(6);
		for (int i = 0; i < 32; i++) begin
			ser_clk_in <= 1'b0;
			ser_data_in <= f[31 - i];
			tick(6);
			// Host takes each read bit just before its rising clock
			if (rd && i > 15) r[31 - i] = ser_data_out;
			ser_clk_in <= 1'b1;
			tick(6);
		end
		ser_clk_in <= 1'b0;
		tick(6);
		ser_sel_n_in <= 1'b1;
		tick(6);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		xfer(1'b1, a, 16'h0000);
		chk("read data", e, r);
	endtask
	task automatic wrap_up;
		$display("checked %0d failed %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog against a hung sequence
	initial begin
		tick(60000);
		fails++;
		wrap_up();
	end
	// Main sequence
	initial begin
		tick(5);
		rst_in <= 1'b0;
		tick(3);
		rd_chk(8'h2d, 16'h1170);
		rd_chk(8'h2e, 16'h0907);
		rd_chk(8'h2f, 16'h1700);
		chk("swing", 16'h0011, 16'(trace_hd_swing_out));
		$display("test reset done");
		xfer(1'b0, 8'h2e, 16'h0a46);
		chk("width", 16'h000a, 16'(cable_hd_preemph_width_out));
		chk("off", 16'h0001, 16'(cable_hd_preemph_off_out));
		chk("level", 16'h0006, 16'(cable_hd_preemph_level_out));
		xfer(1'b0, 8'h2e, 16'h1f3f);
		chk("width", 16'h000f, 16'(cable_hd_preemph_width_out));
		chk("on", 16'h0001, 16'(cable_hd_preemph_on_out));
		chk("level", 16'h000f, 16'(cable_hd_preemph_level_out));
		rd_chk(8'h2e, 16'h1f3f);
		$display("test preemphasis done");
		xfer(1'b0, 8'h2d, 16'h2870);
		chk("swing", 16'h0028, 16'(trace_hd_swing_out));
		xfer(1'b0, 8'h2d, 16'h3f70);
		xfer(1'b0, 8'h30, 16'hffff);
		chk("swing", 16'h0028, 16'(trace_hd_swing_out));
		rd_chk(8'h2d, 16'h3f70);
		rd_chk(8'h30, 16'h0000);
		foreach (sw[k]) begin
			xfer(1'b0, 8'h2f, {2'b00, sw[k], 8'h00});
			chk("cable", 16'(sw[k]), 16'(cable_hd_swing_out));
		end
		rd_chk(8'h2f, 16'h1f00);
		$display("test swing done");
		// Auto slew over every rate, last pass unlocked
		for (int k = 0; k < 6; k++) begin
			recovery_rate_in <= k[2:0];
			recovery_locked_in <= (k < 5);
			tick(2);
			chk("slew", 16'(slew_exp[k]), 16'(slew_select_out));
		end
		automatic_slew_select_in <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			manual_slew_in <= k[1:0];
			tick(2);
			chk("manual", 16'(k), 16'(slew_select_out));
		end
		$display("test slew done");
		wrap_up();
	end
endmodule
`default_nettype wire
